/* tgm_pkg.sv */
// package of offsets, field positions, reset values and carrier types for the
// pin config / adaptive start-temperature control registers.
// assumes an 8-bit register address space and 8-bit register data.
package tgm_pkg;
	// register offsets
	localparam logic [7:0] OFS_PIN_CFG_LOW   = 8'h09; // pins one to four
	localparam logic [7:0] OFS_PIN_CFG_HIGH  = 8'h0A; // pins five to eight
	localparam logic [7:0] OFS_ADAPT_CTRL    = 8'h0B; // adaptive control
	// reset values
	localparam logic [7:0] RST_PIN_CFG       = 8'h00; // both pin config registers
	localparam logic [7:0] RST_ADAPT_CTRL    = 8'h00; // adaptive control
	localparam logic [7:0] RDATA_UNMAPPED    = 8'h00; // answer to unknown offsets
	// pin config fields: per pin, polarity even bit, direction odd bit
	localparam int PIN_POL_POS               = 0;     // polarity bit within pair
	localparam int PIN_DIR_POS               = 1;     // direction bit within pair
	localparam int PINS_PER_REG              = 4;     // pins held by one register
	// adaptive control fields
	localparam int ADAPT_EN_A_POS            = 0;     // channel a adaptive enable
	localparam int ADAPT_EN_B_POS            = 1;     // channel b adaptive enable
	localparam int PIN_A_LATCH_CHAN_A_POS    = 2;     // pin a copies channel a
	localparam int PIN_A_LATCH_CHAN_B_POS    = 3;     // pin a copies channel b
	localparam int PIN_B_LATCH_CHAN_A_POS    = 4;     // pin b copies channel a
	localparam int PIN_B_LATCH_CHAN_B_POS    = 5;     // pin b copies channel b
	localparam logic [7:0] ADAPT_WR_MASK     = 8'h3F; // bits 7:6 reserved, read zero

	// operating point copy request for one channel
	typedef struct packed {
		logic       load;  // one-cycle load strobe
		logic [7:0] value; // temperature to store
	} tgm_op_copy_t;

	// register access request from the serial bus front end
	typedef struct packed {
		logic       wr;    // write strobe
		logic       rd;    // read strobe
		logic [7:0] addr;  // register offset
		logic [7:0] wdata; // write data
	} tgm_reg_req_t;
endpackage

/* tgm_pin_sync.sv */
// two-flop synchroniser and assertion-edge detector for active-low pins.
// assumes pins are asynchronous to clk; freezes while ce is low.
`timescale 1ns/1ns
module tgm_pin_sync #(
	parameter int W = 2 // number of pins
) (
	input  wire logic         clk,          // system clock
	input  wire logic         reset,        // synchronous reset, active high
	input  wire logic         ce,           // clock enable
	input  wire logic [W-1:0] pin_n,        // raw active-low pins
	output logic      [W-1:0] asserted,     // synchronised assertion level
	output logic      [W-1:0] assert_pulse  // first cycle of an assertion
);
	logic [W-1:0] meta_r;  // first stage, read only by second stage
	logic [W-1:0] sync_r;  // second stage
	logic [W-1:0] prev_r;  // delayed copy for edge detect

	// synchroniser chain, idle level is high (deasserted)
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= '1;
			sync_r <= '1;
			prev_r <= '1;
		end else if (ce) begin
			meta_r <= pin_n;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// falling edge on the pin means a new assertion
	assign asserted     = ~sync_r;
	assign assert_pulse = ~sync_r & prev_r;
endmodule // tgm_pin_sync

/* tgm_config_regs.sv */
// pin polarity/direction registers and adaptive start-temperature control,
// with thermal-pin triggered operating point copy for two remote channels.
// assumes the serial bus front end and the temperature logic share clk.
//
// Summary of operation
// - polarity bit: zero active low, one high
// - direction bit: zero input, one output
// - low register pins 1-4, high 5-8
// - registers zero on power-on, soft reset; lockable
// - bit 0 enables adaptive control channel a
// - bit 1 enables adaptive control channel b
// - bit 2: pin a copies channel a
// - bit 3: pin a copies channel b
// - bit 4: pin b copies channel a
// - bit 5: pin b copies channel b
// - copy only if temperature below operating point
// - cleared copy bit ignores pin, keeps value
// - bits 7:6 reserved, zero, no function
`timescale 1ns/1ns
module tgm_config_regs #(
	parameter int TEMP_W = 8 // temperature width
) (
	input  wire logic                 clk,            // system clock, 100 MHz
	input  wire logic                 reset,          // power-on reset, sync, high
	input  wire logic                 ce,             // clock enable
	input  wire logic                 soft_reset,     // software reset pulse
	input  wire logic                 reg_lock,       // device-wide register lock
	input  wire tgm_pkg::tgm_reg_req_t reg_req,       // register access request
	output logic      [7:0]           reg_rdata,      // read data, next cycle
	input  wire logic                 thermal_pin_a_n,// thermal pin a, active low
	input  wire logic                 thermal_pin_b_n,// thermal pin b, active low
	input  wire logic [TEMP_W-1:0]    temp_chan_a,    // channel a current temp
	input  wire logic [TEMP_W-1:0]    temp_chan_b,    // channel b current temp
	input  wire logic [TEMP_W-1:0]    op_point_a,     // channel a operating point
	input  wire logic [TEMP_W-1:0]    op_point_b,     // channel b operating point
	output logic      [7:0]           pin_polarity,   // per pin, one = active high
	output logic      [7:0]           pin_direction,  // per pin, one = output
	output logic      [1:0]           adapt_enable,   // adaptive control per channel
	output tgm_pkg::tgm_op_copy_t     op_copy_a,      // channel a operating point load
	output tgm_pkg::tgm_op_copy_t     op_copy_b       // channel b operating point load
);
	logic [7:0]            pin_cfg_low_r;   // pins one to four
	logic [7:0]            pin_cfg_high_r;  // pins five to eight
	logic [7:0]            adapt_ctrl_r;    // adaptive control
	logic [1:0]            pin_asserted;    // synchronised thermal pin levels
	logic [1:0]            pin_pulse;       // new thermal pin assertions
	logic                  trig_a;          // copy requested for channel a
	logic                  trig_b;          // copy requested for channel b
	logic                  below_a;         // channel a under its operating point
	logic                  below_b;         // channel b under its operating point
	logic                  wr_ok;           // write accepted this cycle
	tgm_pkg::tgm_op_copy_t op_copy_a_r;     // registered load for channel a
	tgm_pkg::tgm_op_copy_t op_copy_b_r;     // registered load for channel b

	// true when a write to this offset may land
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_ok && (reg_req.addr == ofs);
	endfunction

	// thermal pins come from outside: synchronise and detect assertion
	tgm_pin_sync #(
		.W            (2)
	) u_pin_sync (
		.clk          (clk),
		.reset        (reset),
		.ce           (ce),
		.pin_n        ({thermal_pin_b_n, thermal_pin_a_n}),
		.asserted     (pin_asserted),
		.assert_pulse (pin_pulse)
	);

	// locked registers drop host writes; writes land again once reg_lock is low
	assign wr_ok = reg_req.wr && !reg_lock && !soft_reset;

	// pin config registers
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_cfg_low_r  <= tgm_pkg::RST_PIN_CFG;
			pin_cfg_high_r <= tgm_pkg::RST_PIN_CFG;
		end else if (ce) begin
			if (soft_reset) begin
				pin_cfg_low_r  <= tgm_pkg::RST_PIN_CFG;
				pin_cfg_high_r <= tgm_pkg::RST_PIN_CFG;
			end else begin
				if (wr_hit(tgm_pkg::OFS_PIN_CFG_LOW))
					pin_cfg_low_r <= reg_req.wdata;
				if (wr_hit(tgm_pkg::OFS_PIN_CFG_HIGH))
					pin_cfg_high_r <= reg_req.wdata;
			end
		end
	end

	// adaptive control register, reserved bits never stored
	always_ff @(posedge clk) begin
		if (reset) begin
			adapt_ctrl_r <= tgm_pkg::RST_ADAPT_CTRL;
		end else if (ce) begin
			if (soft_reset)
				adapt_ctrl_r <= tgm_pkg::RST_ADAPT_CTRL;
			else if (wr_hit(tgm_pkg::OFS_ADAPT_CTRL))
				adapt_ctrl_r <= reg_req.wdata & tgm_pkg::ADAPT_WR_MASK;
		end
	end

	// read data register, unknown offsets read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= tgm_pkg::RDATA_UNMAPPED;
		end else if (ce && reg_req.rd) begin
			unique case (reg_req.addr)
				tgm_pkg::OFS_PIN_CFG_LOW:  reg_rdata <= pin_cfg_low_r;
				tgm_pkg::OFS_PIN_CFG_HIGH: reg_rdata <= pin_cfg_high_r;
				tgm_pkg::OFS_ADAPT_CTRL:   reg_rdata <= adapt_ctrl_r;
				default:                   reg_rdata <= tgm_pkg::RDATA_UNMAPPED;
			endcase
		end
	end

	// unpack pin pairs: polarity even bit, direction odd bit
	genvar gi;
	generate
		for (gi = 0; gi < tgm_pkg::PINS_PER_REG; gi++) begin : g_pin
			assign pin_polarity[gi] = pin_cfg_low_r[2*gi + tgm_pkg::PIN_POL_POS];
			assign pin_direction[gi] = pin_cfg_low_r[2*gi + tgm_pkg::PIN_DIR_POS];
			assign pin_polarity[gi + tgm_pkg::PINS_PER_REG] =
				pin_cfg_high_r[2*gi + tgm_pkg::PIN_POL_POS];
			assign pin_direction[gi + tgm_pkg::PINS_PER_REG] =
				pin_cfg_high_r[2*gi + tgm_pkg::PIN_DIR_POS];
		end
	endgenerate

	// adaptive loop enables go to the control loop
	assign adapt_enable[0] = adapt_ctrl_r[tgm_pkg::ADAPT_EN_A_POS];
	assign adapt_enable[1] = adapt_ctrl_r[tgm_pkg::ADAPT_EN_B_POS];

	// pin-to-channel copy selection; a cleared bit ignores its pin
	assign trig_a = (pin_pulse[0] && adapt_ctrl_r[tgm_pkg::PIN_A_LATCH_CHAN_A_POS])
		|| (pin_pulse[1] && adapt_ctrl_r[tgm_pkg::PIN_B_LATCH_CHAN_A_POS]);
	assign trig_b = (pin_pulse[0] && adapt_ctrl_r[tgm_pkg::PIN_A_LATCH_CHAN_B_POS])
		|| (pin_pulse[1] && adapt_ctrl_r[tgm_pkg::PIN_B_LATCH_CHAN_B_POS]);

	// copy only moves the operating point down
	assign below_a = temp_chan_a < op_point_a;
	assign below_b = temp_chan_b < op_point_b;

	// operating point load strobes, one cycle each
	always_ff @(posedge clk) begin
		if (reset) begin
			op_copy_a_r <= '0;
			op_copy_b_r <= '0;
		end else if (ce) begin
			op_copy_a_r.load  <= trig_a && below_a;
			op_copy_a_r.value <= temp_chan_a;
			op_copy_b_r.load  <= trig_b && below_b;
			op_copy_b_r.value <= temp_chan_b;
		end
	end

	assign op_copy_a = op_copy_a_r;
	assign op_copy_b = op_copy_b_r;

	// a locked write leaves every register unchanged
	chk_lock_blocks_write: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_lock && reg_req.wr && !soft_reset) |=>
		($stable(pin_cfg_low_r) && $stable(pin_cfg_high_r) && $stable(adapt_ctrl_r)))
		else $error("locked write changed a register");

	// an unlocked write to the low register lands next cycle
	chk_write_low_lands: assert property (@(posedge clk) disable iff (reset)
		(ce && !reg_lock && !soft_reset && reg_req.wr
			&& reg_req.addr == tgm_pkg::OFS_PIN_CFG_LOW) |=>
		(pin_cfg_low_r == $past(reg_req.wdata) && pin_polarity[0] == $past(reg_req.wdata[0])))
		else $error("low pin config write lost");

	// software reset clears all three registers
	chk_soft_reset_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && soft_reset) |=>
		(pin_cfg_low_r == 8'h00 && pin_cfg_high_r == 8'h00 && adapt_ctrl_r == 8'h00))
		else $error("soft reset left a register set");

	// power-on reset leaves all pins inputs, active low
	chk_reset_defaults: assert property (@(posedge clk)
		reset |=> (pin_direction == 8'h00 && pin_polarity == 8'h00 && adapt_enable == 2'b00))
		else $error("pins not at reset default");

	// reserved bits read back zero
	chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
		(ce && reg_req.rd && reg_req.addr == tgm_pkg::OFS_ADAPT_CTRL) |=>
		(reg_rdata[7:6] == 2'b00 && reg_rdata == $past(adapt_ctrl_r)))
		else $error("reserved bits not zero");

	// a selected assertion under the operating point copies the temperature
	chk_copy_a_fires: assert property (@(posedge clk) disable iff (reset)
		(ce && trig_a && below_a) |=>
		(op_copy_a.load && op_copy_a.value == $past(temp_chan_a)))
		else $error("channel a copy missed");

	// no channel b copy when its temperature is not below the operating point
	chk_copy_needs_below: assert property (@(posedge clk) disable iff (reset)
		(ce && !below_b) |=> !op_copy_b.load)
		else $error("channel b copied while not below");

	// pin a with its channel b bit clear does nothing to channel b
	chk_copy_b_ignored: assert property (@(posedge clk) disable iff (reset)
		(ce && !adapt_ctrl_r[tgm_pkg::PIN_A_LATCH_CHAN_B_POS]
			&& !(pin_pulse[1] && adapt_ctrl_r[tgm_pkg::PIN_B_LATCH_CHAN_B_POS])) |=>
		!op_copy_b.load)
		else $error("channel b copied with bit clear");

	// pin a with its channel b bit set copies channel b
	chk_copy_b_fires: assert property (@(posedge clk) disable iff (reset)
		(ce && pin_pulse[0] && adapt_ctrl_r[tgm_pkg::PIN_A_LATCH_CHAN_B_POS]
			&& temp_chan_b < op_point_b) |=>
		(op_copy_b.load && op_copy_b.value == $past(temp_chan_b)))
		else $error("pin a copy to channel b missed");

	// pin b with its channel b bit set copies channel b
	chk_pin_b_copies: assert property (@(posedge clk) disable iff (reset)
		(ce && pin_pulse[1] && adapt_ctrl_r[tgm_pkg::PIN_B_LATCH_CHAN_B_POS]
			&& temp_chan_b < op_point_b) |=>
		(op_copy_b.load && op_copy_b.value == $past(temp_chan_b)))
		else $error("pin b copy to channel b missed");

	// a load never appears without a synchronised pin assertion behind it
	chk_load_needs_pin: assert property (@(posedge clk) disable iff (reset)
		(op_copy_a.load || op_copy_b.load) |->
		($past(pin_asserted) != 2'b00))
		else $error("load without thermal pin assertion");
endmodule // tgm_config_regs

/* tgm_host_model.sv */
// host-side model: issues register requests as the serial bus front end would.
// assumes the testbench calls xfer; requests change at the falling edge.
`timescale 1ns/1ns
module tgm_host_model (
	input  wire logic          clk,  // system clock
	output tgm_pkg::tgm_reg_req_t req,  // register request
	input  wire logic [7:0]    rdata // read data, one cycle later
);
	// one access; the request is held over exactly one rising edge.
	// when idle, address and data are inverted so nothing stale looks valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		req = {w, ~w, a, d};
		@(negedge clk);
		q = rdata;
		req = {1'b0, 1'b0, ~a, ~d};
	endtask

	// quiet bus at time zero
	initial req = '0;
endmodule // tgm_host_model

/* tb_top.sv */
// self-checking bench for the pin config and adaptive control registers.
// assumes a single 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, reset = 1, ce = 1, soft_reset = 0; // clock and resets
	logic reg_lock = 0, pa_n = 1, pb_n = 1;            // lock, thermal pins
	logic [7:0] ta = 0, tb_ = 0, oa = 0, ob = 0;       // temps, op points
	logic [7:0] rdata, pol, dir, q;                    // design outputs
	logic [1:0] aen;                                   // adaptive enables
	logic [7:0] offs[3] = '{8'h09, 8'h0A, 8'h0B};      // mapped offsets
	tgm_pkg::tgm_reg_req_t req;                        // host request
	tgm_pkg::tgm_op_copy_t ca, cb;                     // copy outputs
	int n_fail = 0;                                    // mismatches
	int comparisons = 0;                               // compares made

	// clock, 10 ns period
	always #5 clk = ~clk;

	tgm_host_model i_tgm_host_model (.clk(clk), .req(req), .rdata(rdata));
	tgm_config_regs i_tgm_config_regs (.clk(clk), .reset(reset), .ce(ce),
		.soft_reset(soft_reset), .reg_lock(reg_lock), .reg_req(req),
		.reg_rdata(rdata), .thermal_pin_a_n(pa_n), .thermal_pin_b_n(pb_n),
		.temp_chan_a(ta), .temp_chan_b(tb_), .op_point_a(oa), .op_point_b(ob),
		.pin_polarity(pol), .pin_direction(dir), .adapt_enable(aen),
		.op_copy_a(ca), .op_copy_b(cb));

	// compare one 8-bit result
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// register access helpers
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_tgm_host_model.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		i_tgm_host_model.xfer(1'b0, a, 8'h00, q);
	endtask

	// gather polarity (b=0) or direction (b=1) bits of four pins
	function automatic logic [3:0] pick(input logic [7:0] d, input int b);
		for (int i = 0; i < 4; i++) pick[i] = d[2*i+b];
	endfunction

	// all three registers and decoded outputs read zero
	task automatic t_zero(input string s);
		foreach (offs[i]) begin
			rd(offs[i]);
			check(q, 8'h00);
		end
		check(pol, 8'h00);
		check(dir, 8'h00);
		check({6'h00, aen}, 8'h00);
		$display("test %s done", s);
	endtask

	// pin pairs land on the right outputs
	task automatic t_pins();
		wr(8'h09, 8'h1B);
		wr(8'h0A, 8'hE4);
		check(pol, {pick(8'hE4, 0), pick(8'h1B, 0)});
		check(dir, {pick(8'hE4, 1), pick(8'h1B, 1)});
		rd(8'h0A);
		check(q, 8'hE4);
		$display("test pins done");
	endtask

	// adaptive enables, reserved bits, unmapped offset
	task automatic t_adapt();
		wr(8'h0B, 8'hFF);
		rd(8'h0B);
		check(q, 8'h3F);
		check({6'h00, aen}, 8'h03);
		wr(8'h0B, 8'h02);
		check({6'h00, aen}, 8'h02);
		wr(8'h0C, 8'h5A);
		rd(8'h0C);
		check(q, 8'h00); // unmapped offset reads zero
		rd(8'h0B);
		check(q, 8'h02);
		$display("test adapt done");
	endtask

	// lock drops writes; software reset still clears
	task automatic t_lock();
		@(negedge clk) reg_lock = 1;
		wr(8'h09, 8'h55);
		rd(8'h09);
		check(q, 8'h1B);
		@(negedge clk) soft_reset = 1;
		@(negedge clk) soft_reset = 0;
		t_zero("soft_reset");
		@(negedge clk) reg_lock = 0;
		$display("test lock done");
	endtask

	// clock enable low freezes writes; a later read shows the old value
	task automatic t_ce();
		@(negedge clk) ce = 0;
		wr(8'h09, 8'h3C);
		check(pol, {pick(8'hE4, 0), pick(8'h1B, 0)});
		@(negedge clk) ce = 1;
		rd(8'h09);
		check(q, 8'h1B);
		$display("test ce done");
	endtask

	// assert one pin, collect loads for eight cycles, then release it
	task automatic fire(input logic pin, input logic [1:0] exp);
		logic [1:0] got;
		int n_ld;
		got = 2'b00;
		n_ld = 0;
		@(negedge clk);
		if (pin) pb_n = 0;
		else pa_n = 0;
		repeat (8) begin
			@(posedge clk);
			#1;
			got |= {cb.load, ca.load};
			n_ld += ca.load + cb.load;
			if (ca.load) check(ca.value, ta);
			if (cb.load) check(cb.value, tb_);
		end
		@(negedge clk);
		pa_n = 1;
		pb_n = 1;
		repeat (3) @(negedge clk);
		check({6'h00, got}, {6'h00, exp});
		check(n_ld[7:0], {7'h00, exp[0]} + {7'h00, exp[1]});
	endtask

	// every copy-select bit, equal temperature, cleared bits
	task automatic t_copy();
		@(negedge clk);
		ta = 8'h1E;
		tb_ = 8'h32;
		oa = 8'h28;
		ob = 8'h3C;
		for (int k = 0; k < 4; k++) begin
			wr(8'h04 << k, 8'h00);
			wr(8'h0B, 8'h04 << k);
			fire(k[1], k[0] ? 2'b10 : 2'b01);
		end
		wr(8'h0B, 8'h3C);
		oa = 8'h1E;
		fire(1'b0, 2'b10);
		ob = 8'h32;
		fire(1'b1, 2'b00);
		oa = 8'h28;
		ob = 8'h3C;
		wr(8'h0B, 8'h00);
		fire(1'b1, 2'b00);
		$display("test copy done");
	endtask

	// counts, verdict, end of run
	task automatic final_report();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(negedge clk);
		reset = 0;
		t_zero("reset");
		t_pins();
		t_ce();
		t_adapt();
		t_lock();
		t_copy();
		final_report();
	end

	// watchdog, far beyond the roughly 165 cycles the tests need
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
endmodule // tb_top
